// ==== src/flash_pkg.sv ====
`default_nettype none

package flash_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_PROG = 8'h12;
  localparam logic [7:0] OP_ERASE = 8'h21;
  localparam logic [7:0] OP_PROT_EN = 8'h31;
  localparam logic [7:0] OP_LOCK = 8'h34;
  localparam logic [7:0] OP_PROT_WR = 8'h38;
  localparam logic [7:0] OP_PAGE256 = 8'h41;
  localparam logic [7:0] OP_BUF1_WR = 8'h51;
  localparam logic [7:0] OP_BUF2_WR = 8'h52;
  localparam logic [7:0] OP_BUF1_RD = 8'h61;
  localparam logic [7:0] OP_BUF2_RD = 8'h62;

  // ----------------------------------------
  // Geometry and timing
  // ----------------------------------------
  localparam int PAGE_STD = 264;
  localparam int PAGE_BIN = 256;
  localparam int ADDR_BYTES = 3;
  localparam int SECTORS = 8;
  localparam int SEC_LSB = 16;
  localparam int CLK_MHZ = 40;
  localparam int OP_TIME_NS = 200000;
  localparam int OP_CYCLES = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] SYNC_RST = 4'h7;

  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_DROP} cmd_e;

endpackage

`default_nettype wire

// ==== src/link_if.sv ====
`default_nettype none

interface link_if;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic [7:0] tx_byte;
  modport link (output rx_byte, output rx_tgl, input tx_byte);
  modport core (input rx_byte, input rx_tgl, output tx_byte);
endinterface

`default_nettype wire

// ==== src/spi_link.sv ====
`default_nettype none

module spi_link (
  // Pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Power-on reset
  input wire logic rst,
  // Core side
  link_if.link lk
);

  typedef struct packed {
    logic [6:0] sh;
    logic [2:0] cnt;
    logic [7:0] rx;
    logic tgl;
  } rise_s;

  typedef struct packed {
    logic [6:0] sh;
    logic so;
    logic oe;
  } fall_s;

  rise_s r_r, r_nxt;
  fall_s f_r, f_nxt;
  logic armed_r;
  logic link_rst;

  // Frame reset; a rise of select mid-byte lands here
  assign link_rst = cs_n | rst;

  // ----------------------------------------
  // Rising edge: capture
  // ----------------------------------------
  always_comb begin
    r_nxt = r_r;
    r_nxt.cnt = armed_r ? 3'h1 : r_r.cnt + 3'h1;
    r_nxt.sh = {r_r.sh[5:0], si};
    if (r_nxt.cnt == 3'h0) begin
      r_nxt.rx = {r_r.sh, si};
      r_nxt.tgl = ~r_r.tgl;
    end
  end

  // Toggle is not cleared by deselect, so the core never sees a false event
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      armed_r <= 1'b1;
    end else begin
      armed_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Falling edge: drive
  // ----------------------------------------
  always_comb begin
    f_nxt = f_r;
    f_nxt.oe = 1'b1;
    if (r_r.cnt == 3'h0) begin
      f_nxt.so = lk.tx_byte[7];
      f_nxt.sh = lk.tx_byte[6:0];
    end else begin
      f_nxt.so = f_r.sh[6];
      f_nxt.sh = {f_r.sh[5:0], 1'b0};
    end
  end

  // Mode 3 gives a falling edge before the first capture; it loads, or shifts if the last frame ended mid-byte
  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  assign so = f_r.so;
  assign so_oe = f_r.oe;
  assign lk.rx_byte = r_r.rx;
  assign lk.rx_tgl = r_r.tgl;

endmodule

`default_nettype wire

// ==== src/flash_pins.sv ====
`default_nettype none

module flash_pins #(
  parameter int OP_CYCLES = flash_pkg::OP_CYCLES,
  parameter int BUF_DEPTH = flash_pkg::PAGE_STD,
  parameter int SECTORS = flash_pkg::SECTORS
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Control pins
  input wire logic wp_n,
  input wire logic reset_n,
  // Status
  output logic busy,
  output logic standby,
  output logic page_256,
  output logic refused
);

  localparam int BW = $clog2(OP_CYCLES + 1);
  localparam int SW = $clog2(SECTORS);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (BUF_DEPTH < flash_pkg::PAGE_STD || BUF_DEPTH > 512) begin : g_bad_depth
      $error("BUF_DEPTH must hold one full page and fit a 9-bit index");
    end
    if (OP_CYCLES < 1) begin : g_bad_time
      $error("OP_CYCLES must be at least one");
    end
    if (SECTORS < 2 || SECTORS > 8) begin : g_bad_sec
      $error("SECTORS must lie between 2 and 8");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] flt;
    flash_pkg::cmd_e st;
    logic [7:0] opc;
    logic [1:0] acnt;
    logic [23:0] addr;
    logic pend;
    logic busy;
    logic [BW-1:0] bcnt;
    logic standby;
    logic page_256;
    logic sw_prot;
    logic [SECTORS-1:0] tbl;
    logic [SECTORS-1:0] lock;
    logic [8:0] bidx;
    logic [7:0] tx;
    logic refused;
    logic [1:0][BUF_DEPTH-1:0][7:0] mem;
  } core_s;

  core_s r, n;
  link_if lk ();

  logic rx_ev;
  logic cs_fall;
  logic cs_rise;
  logic wp_on;
  logic bsel;
  logic [7:0] rxb;
  logic [7:0] stat;
  logic [8:0] psz;
  logic [8:0] idx;
  logic [23:0] a;
  logic [SW-1:0] sec;

  function automatic logic [8:0] next_idx(logic [8:0] i, logic [8:0] p);
    logic [8:0] s;
    s = i + 9'h001;
    return (s == p) ? 9'h000 : s;
  endfunction

  // ----------------------------------------
  // Link side
  // ----------------------------------------
  spi_link u_link (
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .so(so),
    .so_oe(so_oe),
    .rst(rst),
    .lk(lk.link)
  );

  assign lk.tx_byte = r.tx;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.refused = 1'b0;

    // Bit 0 select, 1 write protect, 2 reset pin, 3 byte toggle
    n.s1 = {lk.rx_tgl, reset_n, wp_n, cs_n};
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < 4; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.flt[i] = r.s3[i];
      end
    end

    rx_ev = (r.s2[3] == r.s3[3]) && (r.s3[3] != r.flt[3]);
    rxb = lk.rx_byte;
    cs_fall = r.flt[0] & ~n.flt[0];
    cs_rise = ~r.flt[0] & n.flt[0];
    wp_on = ~r.flt[1];
    psz = r.page_256 ? 9'(flash_pkg::PAGE_BIN) : 9'(flash_pkg::PAGE_STD);
    a = {r.addr[15:0], rxb};
    sec = a[flash_pkg::SEC_LSB +: SW];
    idx = (a[8:0] < psz) ? a[8:0] : 9'h000;
    bsel = (r.opc == flash_pkg::OP_BUF2_WR) || (r.opc == flash_pkg::OP_BUF2_RD);
    stat = {~r.busy, r.page_256, r.sw_prot, wp_on, 4'h0};

    // Self-timed array operation
    if (r.busy) begin
      n.bcnt = r.bcnt - BW'(1);
      if (r.bcnt == BW'(1)) begin
        n.busy = 1'b0;
      end
    end

    unique case (r.st)
      flash_pkg::ST_IDLE: begin
        if (cs_fall) begin
          n.st = flash_pkg::ST_OPC;
        end
      end

      flash_pkg::ST_OPC: begin
        if (rx_ev) begin
          n.opc = rxb;
          n.acnt = 2'h0;
          n.st = flash_pkg::ST_DROP;
          // Only status reads and buffer 2 writes stay open while the array is busy
          if (r.busy && rxb != flash_pkg::OP_STATUS && rxb != flash_pkg::OP_BUF2_WR) begin
            n.refused = 1'b1;
          end else begin
            case (rxb)
              flash_pkg::OP_STATUS: begin
                n.st = flash_pkg::ST_DATA;
              end
              flash_pkg::OP_PROT_EN: begin
                n.sw_prot = 1'b1;
              end
              flash_pkg::OP_PAGE256: begin
                n.page_256 = 1'b1;
              end
              flash_pkg::OP_PROG,
              flash_pkg::OP_ERASE,
              flash_pkg::OP_LOCK,
              flash_pkg::OP_PROT_WR,
              flash_pkg::OP_BUF1_WR,
              flash_pkg::OP_BUF2_WR,
              flash_pkg::OP_BUF1_RD,
              flash_pkg::OP_BUF2_RD: begin
                n.st = flash_pkg::ST_ADDR;
              end
              default: begin
                n.st = flash_pkg::ST_DROP;
              end
            endcase
          end
        end
      end

      flash_pkg::ST_ADDR: begin
        if (rx_ev) begin
          n.addr = a;
          n.acnt = r.acnt + 2'h1;
          if (r.acnt == 2'(flash_pkg::ADDR_BYTES - 1)) begin
            n.st = flash_pkg::ST_DROP;
            case (r.opc)
              flash_pkg::OP_PROG,
              flash_pkg::OP_ERASE: begin
                if (wp_on) begin
                  n.refused = 1'b1;
                end else if ((r.sw_prot & r.tbl[sec]) | r.lock[sec]) begin
                  n.refused = 1'b1;
                end else begin
                  n.pend = 1'b1;
                end
              end
              flash_pkg::OP_LOCK: begin
                n.lock[sec] = 1'b1;
              end
              flash_pkg::OP_PROT_WR: begin
                if (wp_on) begin
                  n.refused = 1'b1;
                end else begin
                  n.st = flash_pkg::ST_DATA;
                end
              end
              flash_pkg::OP_BUF1_RD,
              flash_pkg::OP_BUF2_RD: begin
                n.tx = r.mem[bsel][idx];
                n.bidx = next_idx(idx, psz);
                n.st = flash_pkg::ST_DATA;
              end
              default: begin
                n.bidx = idx;
                n.st = flash_pkg::ST_DATA;
              end
            endcase
          end
        end
      end

      flash_pkg::ST_DATA: begin
        if (rx_ev) begin
          case (r.opc)
            flash_pkg::OP_PROT_WR: begin
              if (wp_on) begin
                n.refused = 1'b1;
              end else begin
                n.tbl = rxb[SECTORS-1:0];
              end
              n.st = flash_pkg::ST_DROP;
            end
            flash_pkg::OP_BUF1_WR,
            flash_pkg::OP_BUF2_WR: begin
              n.mem[bsel][r.bidx] = rxb;
              n.bidx = next_idx(r.bidx, psz);
            end
            flash_pkg::OP_BUF1_RD,
            flash_pkg::OP_BUF2_RD: begin
              n.tx = r.mem[bsel][r.bidx];
              n.bidx = next_idx(r.bidx, psz);
            end
            default: begin
              n.tx = stat;
            end
          endcase
        end
      end

      flash_pkg::ST_DROP: begin
        n.st = flash_pkg::ST_DROP;
      end

      default: begin
        n.st = flash_pkg::ST_IDLE;
      end
    endcase

    // Status leads the link so it is ready at the first output edge
    if (n.st == flash_pkg::ST_IDLE || n.st == flash_pkg::ST_OPC ||
        (n.st == flash_pkg::ST_DATA && n.opc == flash_pkg::OP_STATUS)) begin
      n.tx = {~n.busy, n.page_256, n.sw_prot, wp_on, 4'h0};
    end

    // Frame end; a partial byte never raised an event
    if (cs_rise) begin
      n.st = flash_pkg::ST_IDLE;
      n.acnt = 2'h0;
      if (n.pend) begin
        n.busy = 1'b1;
        n.bcnt = BW'(OP_CYCLES);
        n.pend = 1'b0;
      end
    end

    // Reset pin holds everything idle while low
    if (~r.flt[2]) begin
      n.st = flash_pkg::ST_IDLE;
      n.busy = 1'b0;
      n.bcnt = '0;
      n.pend = 1'b0;
      n.refused = 1'b0;
    end

    n.standby = n.flt[0] & ~n.busy;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.s1 <= flash_pkg::SYNC_RST;
      r.s2 <= flash_pkg::SYNC_RST;
      r.s3 <= flash_pkg::SYNC_RST;
      r.flt <= flash_pkg::SYNC_RST;
      r.st <= flash_pkg::ST_IDLE;
      r.standby <= 1'b1;
      r.tx <= 8'h80;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign busy = r.busy;
  assign standby = r.standby;
  assign page_256 = r.page_256;
  assign refused = r.refused;

endmodule

`default_nettype wire

// ==== dv/flash_pins_props.sv ====
`default_nettype none

module flash_pins_props #(
  parameter int OP_CYCLES = 20
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  // Control and status
  input wire logic wp_n,
  input wire logic reset_n,
  input wire logic busy,
  input wire logic standby,
  input wire logic page_256,
  input wire logic refused
);
  // Busy length counter; one cycle of slack for the start-up edge
  int busy_cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= busy ? busy_cnt_r + 1 : 0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_so_quiet: assert property (cs_n |-> !so_oe)
    else $error("output enabled while deselected");
  a_busy_bound: assert property (busy |-> busy_cnt_r < OP_CYCLES + 1)
    else $error("self-timed operation runs too long");
  a_busy_full: assert property ($fell(busy) && reset_n && $past(reset_n, 6) |->
    busy_cnt_r >= OP_CYCLES - 1) else $error("self-timed operation cut short");
  a_busy_no_standby: assert property (busy && $past(busy, 2) |-> !standby)
    else $error("standby while busy");
  a_sel_no_standby: assert property ((!cs_n)[*8] |-> !standby)
    else $error("standby while selected");
  a_standby_idle: assert property ($rose(standby) |-> !busy)
    else $error("standby entered from busy");
  a_ref_pulse: assert property (refused |=> !refused)
    else $error("refused longer than one cycle");
  a_wp_no_start: assert property ($rose(busy) |-> wp_n)
    else $error("operation started under write protect");
  a_reset_idle: assert property ((!reset_n)[*8] |-> !busy && !refused)
    else $error("activity while reset pin low");
  a_page_default: assert property ($past(rst) |-> !page_256)
    else $error("page size not default after reset");
  a_page_hold: assert property (page_256 |=> page_256)
    else $error("page size changed back");
endmodule

bind flash_pins flash_pins_props #(.OP_CYCLES(OP_CYCLES)) flash_pins_props_i (
  .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
  .wp_n(wp_n), .reset_n(reset_n), .busy(busy), .standby(standby),
  .page_256(page_256), .refused(refused)
);

`default_nettype wire

// ==== dv/spi_host.sv ====
`default_nettype none

module spi_host (
  // Pins
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime HALF = 80ns;
  logic mode3;

  initial begin
    mode3 = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // Clock stands at its idle level outside frames
  task automatic open_frame(input logic m3);
    mode3 = m3;
    sck = m3;
    #(HALF);
    cs_n = 1'b0;
    #(HALF);
  endtask

  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      sck = 1'b0;
      si = tx[i];
      #(HALF);
      sck = 1'b1;
      rx[i] = so_oe ? so : 1'bx;
      #(HALF);
    end
  endtask

  // Released data line flips so stale data is never read as valid
  task automatic close_frame();
    if (!mode3) sck = 1'b0;
    #(HALF);
    cs_n = 1'b1;
    si = ~si;
    #(2 * HALF);
  endtask
endmodule

`default_nettype wire

// ==== dv/serial_flash_pin_interface_test.sv ====
`default_nettype none

module serial_flash_pin_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OPC = 1000;
  logic clk, rst, wp_n, reset_n;
  logic sck, cs_n, si, so, so_oe, busy, standby, page_256, refused;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int ref_seen = 0;
  int r0;
  logic m3 = 1'b0;
  logic m_pg = 1'b0;
  logic m_sw = 1'b0;
  logic [31:0] seed = 32'h5fc0;
  logic [7:0] rx;
  logic [8:0] ix;
  logic [7:0] m_buf [2][264];

  flash_pins #(.OP_CYCLES(OPC)) flash_pins_i (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n),
    .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .reset_n(reset_n), .busy(busy),
    .standby(standby), .page_256(page_256), .refused(refused));
  spi_host host_i (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog well above the longest run
  always @(posedge clk) begin
    cycles++;
    if (refused === 1'b1) ref_seen++;
    if (cycles == 40000) begin
      fail_count++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Every full frame swaps clock mode, so the full frames alternate between the two modes; the partial frame keeps the mode of the next one
  task automatic head(input logic [7:0] op, input logic [23:0] a);
    host_i.open_frame(m3);
    m3 = ~m3;
    host_i.xfer(op, 8, rx);
    for (int i = 2; i >= 0; i--) host_i.xfer(a[8*i+:8], 8, rx);
  endtask

  task automatic op_only(input logic [7:0] op);
    host_i.open_frame(m3);
    m3 = ~m3;
    host_i.xfer(op, 8, rx);
    host_i.close_frame();
    tick(4);
  endtask

  task automatic status();
    host_i.open_frame(m3);
    m3 = ~m3;
    host_i.xfer(8'h05, 8, rx);
    for (int k = 0; k < 2; k++) begin
      host_i.xfer(8'h00, 8, rx);
      check(rx, {1'b1, m_pg, m_sw, ~wp_n, 4'h0});
    end
    host_i.close_frame();
    tick(4);
  endtask

  task automatic buf_io(input logic [7:0] op, input logic [8:0] idx, input int n);
    logic [7:0] d;
    head(op, {15'h0, idx});
    if (op[5]) host_i.xfer(8'h00, 8, rx);
    for (int i = 0; i < n; i++) begin
      if (op[5]) begin
        host_i.xfer(8'h00, 8, rx);
        check(rx, m_buf[op[1]][idx + i]);
      end else begin
        seed = lfsr(seed);
        d = seed[7:0];
        host_i.xfer(d, 8, rx);
        m_buf[op[1]][idx + i] = d;
      end
    end
    host_i.close_frame();
    tick(4);
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (busy !== lvl && k < lim) begin
      tick(1);
      k++;
    end
    check({7'h0, busy}, {7'h0, lvl});
  endtask

  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    reset_n = 1'b1;
    tick(20);
    rst = 1'b0;
    tick(4);
    check({4'h0, busy, standby, page_256, refused}, 8'h04);
    status();
    host_i.open_frame(m3);
    host_i.xfer(8'h05, 4, rx);
    host_i.close_frame();
    tick(4);
    status();
    seed = lfsr(seed);
    ix = {1'b0, seed[7:0]};
    buf_io(8'h51, ix, 6);
    buf_io(8'h61, ix, 6);
    head(8'h12, 24'h000000);
    host_i.close_frame();
    wait_busy(1'b1, 40);
    check({7'h0, standby}, 8'h00);
    buf_io(8'h52, ix, 3);
    check({7'h0, busy}, 8'h01);
    wait_busy(1'b0, 1200);
    tick(3);
    check({7'h0, standby}, 8'h01);
    buf_io(8'h62, ix, 3);
    head(8'h12, 24'h000000);
    host_i.close_frame();
    wait_busy(1'b1, 40);
    reset_n = 1'b0;
    tick(8);
    check({7'h0, busy}, 8'h00);
    op_only(8'h41);
    check({7'h0, page_256}, 8'h00);
    reset_n = 1'b1;
    tick(6);
    op_only(8'h41);
    m_pg = 1'b1;
    check({7'h0, page_256}, 8'h01);
    wp_n = 1'b0;
    tick(4);
    status();
    r0 = ref_seen;
    head(8'h12, 24'h010000);
    host_i.close_frame();
    tick(40);
    check({7'h0, busy}, 8'h00);
    head(8'h38, 24'h000000);
    host_i.xfer(8'hff, 8, rx);
    host_i.close_frame();
    tick(8);
    check(8'(ref_seen - r0), 8'h02);
    op_only(8'h31);
    m_sw = 1'b1;
    head(8'h34, 24'h070000);
    host_i.close_frame();
    tick(8);
    check(8'(ref_seen - r0), 8'h02);
    status();
    wp_n = 1'b1;
    tick(4);
    head(8'h12, 24'h070000);
    host_i.close_frame();
    tick(40);
    check({7'h0, busy}, 8'h00);
    check(8'(ref_seen - r0), 8'h03);
    head(8'h38, 24'h000000);
    host_i.xfer(8'h02, 8, rx);
    host_i.close_frame();
    tick(8);
    head(8'h21, 24'h010000);
    host_i.close_frame();
    tick(40);
    check({7'h0, busy}, 8'h00);
    check(8'(ref_seen - r0), 8'h04);
    test_done();
  end
endmodule

`default_nettype wire
